// ### hw/rss_pkg.sv
package rss_pkg;

    // Register map (byte addresses, one 32-bit word each)
    localparam int               ADDR_W             = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL         = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_START_TIME   = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS       = 8'h08;

    // Control register fields
    localparam int CTRL_MODE_LSB      = 0;
    localparam int CTRL_MODE_BY_INPUT = 2;
    localparam int CTRL_BLOCK_CMD     = 3;
    localparam int CTRL_TWO_RECLOSERS = 4;
    localparam int CTRL_MASTER_SEL    = 5;
    localparam int CTRL_SLAVE_ENABLE  = 6;
    localparam int CTRL_ATTEMPTS_LSB  = 8;
    localparam int CTRL_MASK_LSB      = 16;
    localparam int MASK_W             = 8;

    localparam logic [31:0] CTRL_RESET       = 32'h00FF0103;
    localparam logic [31:0] START_TIME_RESET = 32'h00000064;
    localparam int          START_TIME_W     = 16;

    // Status register layout, nine bits per recloser
    localparam int STATUS_STRIDE      = 9;
    localparam int STATUS_CAUSE_LSB   = 3;
    localparam int STATUS_SEQ_BIT     = 7;
    localparam int STATUS_LOCK_BIT    = 8;
    localparam int STATUS_ATTEMPT_LSB = 18;
    localparam int ATTEMPT_W          = 3;

    localparam logic [ATTEMPT_W-1:0] MIN_ATTEMPTS = 3'h1;
    localparam logic [ATTEMPT_W-1:0] MAX_ATTEMPTS = 3'h4;

    // Start-time tick: 1 ms at 50 MHz
    localparam int TICK_TIME_US = 1000;
    localparam int CLK_MHZ      = 50;
    localparam int TICK_CYCLES  = TICK_TIME_US * CLK_MHZ;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        PH_RESET  = 3'h0,
        PH_SINGLE = 3'h1,
        PH_THREE  = 3'h3,
        PH_SEQ    = 3'h2,
        PH_LOCK   = 3'h6
    } rss_phase_t;

    // Encoding equals {single_phase_mode_input, three_phase_mode_input}
    typedef enum logic [1:0] {
        MODE_DEPENDENT = 2'h0,
        MODE_THREE     = 2'h1,
        MODE_SINGLE    = 2'h2,
        MODE_COMBINED  = 2'h3
    } rss_mode_t;

    typedef enum logic [3:0] {
        CAUSE_NONE          = 4'h0,
        CAUSE_OPEN_BREAKER  = 4'h1,
        CAUSE_THREE_PHASE   = 4'h2,
        CAUSE_START_FAILURE = 4'h3,
        CAUSE_CLOSE_FAILURE = 4'h4,
        CAUSE_FINAL_TRIP    = 4'h5,
        CAUSE_NO_SYNC       = 4'h6,
        CAUSE_BY_MASTER     = 4'h7,
        CAUSE_SWITCH_FAULT  = 4'h8
    } rss_cause_t;

endpackage

// ### hw/rss_recloser_sequence_start.sv
// Summary of operation
// - Single-phase mode: single-phase or external non-3ph trip initiates, enters single-phase start.
// - Single-phase mode: three-phase initiate goes to three-phase-trip lockout.
// - Three-phase mode: three-phase or external 3ph trip initiates, enters three-phase start.
// - Combined and dependent modes: single trips act single-phase, three-phase trips three-phase.
// - A recloser blocked by command stays in Reset.
// - Single-phase start timer expiry before conditions met gives start-failure lockout.
// - Single-phase conditions met in time start sequence, set in-progress, pulse event.
// - Sequence-in-progress holds until Reset or any lockout.
// - Trip turning three-phase in single start: lockout or three-phase start by mode.
// - Three-phase start timer expiry before conditions met gives start-failure lockout.
// - Three-phase conditions met in time start sequence, set in-progress, pulse event.
// - Three-phase trip or all poles open in single start: lockout or three-phase start.
// - Programmable number of attempts, one to four.
// - Two reclosers: one master, the other index is the slave.
// - Single-recloser operation selects recloser 1 or 2 as operative.
// - Distinct lockout causes per recloser and a summary lockout flag.
// - One shared lockout structure for all four modes.
// - Slave lockout by master command, slave enable and slave lockout outputs.
// - Mode inputs decode 00 dependent, 01 three, 10 single, 11 combined.
// - No start when trip count exceeded or initiate block input active.
// - Initiate from masked reclosable trips or external trips only.
`timescale 1ns/1ps
`default_nettype none

module rss_recloser_sequence_start
    import rss_pkg::*;
#(
    parameter int TICK_CYCLES_P = rss_pkg::TICK_CYCLES,
    parameter int N_PROT        = rss_pkg::MASK_W
) (
    input  wire logic                        core_clk,
    input  wire logic                        rst_b,
    // AXI4-Lite slave
    input  wire logic [rss_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [rss_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // Protection trip side
    input  wire logic [N_PROT-1:0]           protTrip,
    input  wire logic                        threePhaseTrip,
    input  wire logic                        tripActive,
    input  wire logic                        extTripActive,
    input  wire logic                        extThreePhaseTripActive,
    input  wire logic                        tripCountExceeded,
    input  wire logic                        initiateBlockInput,
    input  wire logic                        singlePhaseModeInput,
    input  wire logic                        threePhaseModeInput,
    // Breaker pole status and close command, one bit per recloser
    input  wire logic [1:0]                  breakerAnyPoleOpen,
    input  wire logic [1:0]                  breakerAllPolesFlag,
    input  wire logic [1:0]                  breakerThreePolesOpen,
    input  wire logic [1:0]                  breakerCloseCommand,
    // Later sequence stages, one bit per recloser
    input  wire logic [1:0]                  attemptDone,
    input  wire logic [1:0]                  sequenceReset,
    input  wire logic [1:0]                  lockoutOpenBreaker,
    input  wire logic [1:0]                  lockoutClosingFailure,
    input  wire logic [1:0]                  lockoutNoSynchronism,
    input  wire logic [1:0]                  lockoutSwitchOntoFault,
    // Status outputs
    output logic                             recloseInitiate,
    output logic [1:0]                       sequenceInProgress,
    output logic [1:0]                       sequenceStartEvent,
    output logic [1:0]                       anyInternalLockout,
    output logic [1:0]                       singlePhaseStartState,
    output logic [1:0]                       threePhaseStartState,
    output logic [1:0]                       recloserIdle,
    output logic                             slaveEnable,
    output logic                             slaveLockout
);
    import rss_pkg::*;

    localparam int PRE_W = $clog2(TICK_CYCLES_P + 1);

    typedef struct packed {
        logic                               awHave;
        logic                               wHave;
        logic [ADDR_W-1:0]                  awAddr;
        logic [31:0]                        wData;
        logic [3:0]                         wStrb;
        logic                               awReady;
        logic                               wReady;
        logic                               bValid;
        logic [1:0]                         bResp;
        logic                               arReady;
        logic                               rValid;
        logic [31:0]                        rData;
        logic [1:0]                         rResp;
        logic [31:0]                        ctrl;
        logic [START_TIME_W-1:0]            startTime;
        logic [PRE_W-1:0]                   prescale;
        rss_phase_t [1:0]                   phase;
        rss_cause_t [1:0]                   cause;
        logic [1:0][START_TIME_W-1:0]       timer;
        logic [1:0][ATTEMPT_W-1:0]          attempts;
        logic                               initiate;
        logic [1:0]                         seqOut;
        logic [1:0]                         startEvent;
        logic [1:0]                         lockOut;
        logic [1:0]                         singleOut;
        logic [1:0]                         threeOut;
        logic [1:0]                         idleOut;
        logic                               slvEnable;
        logic                               slvLockout;
    } rss_state_t;

    rss_state_t q;
    rss_state_t next_q;

    function automatic logic [31:0] apply_strobe(input logic [31:0] old,
                                                 input logic [31:0] data,
                                                 input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic is_start(input rss_phase_t ph);
        return (ph == PH_SINGLE) || (ph == PH_THREE);
    endfunction

    rss_mode_t               mode;
    logic                    threePh;
    logic                    startAllowed;
    logic                    tick;
    logic                    twoRec;
    logic                    masterIdx;
    logic                    masterHardLock;
    logic [ATTEMPT_W-1:0]    attemptLimit;
    logic                    bkrSingleOk [2];
    logic                    bkrThreeOk [2];
    logic                    allOpen [2];
    logic                    operative [2];
    logic                    expired [2];
    logic                    isMaster [2];

    always_comb begin
        next_q = q;

        // Register bus: address and data taken in either order
        if (s_axi_awvalid && q.awReady) begin
            next_q.awHave = 1'b1;
            next_q.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wReady) begin
            next_q.wHave = 1'b1;
            next_q.wData = s_axi_wdata;
            next_q.wStrb = s_axi_wstrb;
        end
        if (q.bValid && s_axi_bready) begin
            next_q.bValid = 1'b0;
        end
        if (q.awHave && q.wHave && !q.bValid) begin
            next_q.awHave = 1'b0;
            next_q.wHave  = 1'b0;
            next_q.bValid = 1'b1;
            next_q.bResp  = RESP_OKAY;
            case (q.awAddr)
                ADDR_CTRL: begin
                    next_q.ctrl = apply_strobe(q.ctrl, q.wData, q.wStrb);
                end
                ADDR_START_TIME: begin
                    next_q.startTime = START_TIME_W'(apply_strobe(32'(q.startTime),
                                                                   q.wData, q.wStrb));
                end
                ADDR_STATUS: begin
                end
                default: begin
                    next_q.bResp = RESP_SLVERR;
                end
            endcase
        end
        next_q.awReady = !next_q.awHave && !next_q.bValid;
        next_q.wReady  = !next_q.wHave && !next_q.bValid;

        if (q.rValid && s_axi_rready) begin
            next_q.rValid = 1'b0;
        end
        if (s_axi_arvalid && q.arReady) begin
            next_q.rValid = 1'b1;
            next_q.rResp  = RESP_OKAY;
            next_q.rData  = '0;
            case (s_axi_araddr)
                ADDR_CTRL: begin
                    next_q.rData = q.ctrl;
                end
                ADDR_START_TIME: begin
                    next_q.rData = 32'(q.startTime);
                end
                ADDR_STATUS: begin
                    for (int r = 0; r < 2; r++) begin
                        next_q.rData[r*STATUS_STRIDE +: 3] = q.phase[r];
                        next_q.rData[r*STATUS_STRIDE + STATUS_CAUSE_LSB +: 4] = q.cause[r];
                        next_q.rData[r*STATUS_STRIDE + STATUS_SEQ_BIT] = q.seqOut[r];
                        next_q.rData[r*STATUS_STRIDE + STATUS_LOCK_BIT] = q.lockOut[r];
                        next_q.rData[STATUS_ATTEMPT_LSB + r*ATTEMPT_W +: ATTEMPT_W] =
                            q.attempts[r];
                    end
                end
                default: begin
                    next_q.rResp = RESP_SLVERR;
                end
            endcase
        end
        next_q.arReady = !next_q.rValid;

        // Settings decode
        if (q.ctrl[CTRL_MODE_BY_INPUT]) begin
            mode = rss_mode_t'({singlePhaseModeInput, threePhaseModeInput});
        end else begin
            mode = rss_mode_t'(q.ctrl[CTRL_MODE_LSB +: 2]);
        end
        attemptLimit = q.ctrl[CTRL_ATTEMPTS_LSB +: ATTEMPT_W];
        if (attemptLimit < MIN_ATTEMPTS) begin
            attemptLimit = MIN_ATTEMPTS;
        end else if (attemptLimit > MAX_ATTEMPTS) begin
            attemptLimit = MAX_ATTEMPTS;
        end
        twoRec    = q.ctrl[CTRL_TWO_RECLOSERS];
        masterIdx = q.ctrl[CTRL_MASTER_SEL];

        // Initiate from masked reclosable trips or external trips
        next_q.initiate = (|(protTrip & q.ctrl[CTRL_MASK_LSB +: N_PROT]))
                        || extTripActive || extThreePhaseTripActive;
        threePh = threePhaseTrip || extThreePhaseTripActive;
        startAllowed = !q.ctrl[CTRL_BLOCK_CMD] && !initiateBlockInput
                     && !tripCountExceeded;

        // Start-time prescaler runs freely
        tick = (q.prescale == PRE_W'(TICK_CYCLES_P - 1));
        next_q.prescale = tick ? '0 : q.prescale + PRE_W'(1);

        // Master hard lockout drives slave enable or slave lockout
        masterHardLock = twoRec && (q.phase[masterIdx] == PH_LOCK)
                       && ((q.cause[masterIdx] == CAUSE_START_FAILURE)
                           || (q.cause[masterIdx] == CAUSE_THREE_PHASE));
        next_q.slvEnable  = masterHardLock && q.ctrl[CTRL_SLAVE_ENABLE];
        next_q.slvLockout = masterHardLock && !q.ctrl[CTRL_SLAVE_ENABLE];

        for (int r = 0; r < 2; r++) begin
            isMaster[r]  = (r == int'(masterIdx));
            operative[r] = twoRec || isMaster[r];
            // In two-recloser operation the other breaker takes part too
            bkrSingleOk[r] = breakerAnyPoleOpen[r] && !breakerAllPolesFlag[r]
                           && (!twoRec || breakerAnyPoleOpen[1-r]);
            bkrThreeOk[r]  = breakerThreePolesOpen[r]
                           && (!twoRec || breakerThreePolesOpen[1-r]);
            allOpen[r]     = bkrThreeOk[r];
            expired[r]     = (q.timer[r] >= q.startTime);
            next_q.startEvent[r] = 1'b0;

            if (is_start(q.phase[r])) begin
                if (tick) begin
                    next_q.timer[r] = q.timer[r] + START_TIME_W'(1);
                end
            end else begin
                next_q.timer[r] = '0;
            end

            case (q.phase[r])
                PH_RESET: begin
                    next_q.attempts[r] = '0;
                    if (operative[r] && q.initiate && startAllowed) begin
                        if (threePh) begin
                            if (mode == MODE_SINGLE) begin
                                next_q.phase[r] = PH_LOCK;
                                next_q.cause[r] = CAUSE_THREE_PHASE;
                            end else begin
                                next_q.phase[r] = PH_THREE;
                            end
                        end else if (mode != MODE_THREE) begin
                            next_q.phase[r] = PH_SINGLE;
                        end
                    end
                end
                PH_SINGLE: begin
                    if (threePh || allOpen[r]) begin
                        if (mode == MODE_SINGLE) begin
                            next_q.phase[r] = PH_LOCK;
                            next_q.cause[r] = CAUSE_THREE_PHASE;
                        end else begin
                            next_q.phase[r] = PH_THREE;
                            next_q.timer[r] = '0;
                        end
                    end else if (!q.initiate && bkrSingleOk[r] && !tripActive) begin
                        next_q.phase[r]      = PH_SEQ;
                        next_q.startEvent[r] = 1'b1;
                    end else if (expired[r]) begin
                        next_q.phase[r] = PH_LOCK;
                        next_q.cause[r] = CAUSE_START_FAILURE;
                    end
                end
                PH_THREE: begin
                    if (!q.initiate && bkrThreeOk[r] && !tripActive) begin
                        next_q.phase[r]      = PH_SEQ;
                        next_q.startEvent[r] = 1'b1;
                    end else if (expired[r]) begin
                        next_q.phase[r] = PH_LOCK;
                        next_q.cause[r] = CAUSE_START_FAILURE;
                    end
                end
                PH_SEQ: begin
                    if (lockoutOpenBreaker[r]) begin
                        next_q.phase[r] = PH_LOCK;
                        next_q.cause[r] = CAUSE_OPEN_BREAKER;
                    end else if (lockoutClosingFailure[r]) begin
                        next_q.phase[r] = PH_LOCK;
                        next_q.cause[r] = CAUSE_CLOSE_FAILURE;
                    end else if (lockoutNoSynchronism[r]) begin
                        next_q.phase[r] = PH_LOCK;
                        next_q.cause[r] = CAUSE_NO_SYNC;
                    end else if (lockoutSwitchOntoFault[r]) begin
                        next_q.phase[r] = PH_LOCK;
                        next_q.cause[r] = CAUSE_SWITCH_FAULT;
                    end else if (attemptDone[r]) begin
                        if ((q.attempts[r] + ATTEMPT_W'(1)) >= attemptLimit
                            && tripActive) begin
                            next_q.phase[r] = PH_LOCK;
                            next_q.cause[r] = CAUSE_FINAL_TRIP;
                        end else begin
                            next_q.attempts[r] = q.attempts[r] + ATTEMPT_W'(1);
                        end
                    end else if (sequenceReset[r]) begin
                        next_q.phase[r] = PH_RESET;
                    end
                end
                PH_LOCK: begin
                    // Shared lockout exit for every mode
                    if (breakerCloseCommand[r]) begin
                        next_q.phase[r] = PH_RESET;
                        next_q.cause[r] = CAUSE_NONE;
                    end
                end
                default: begin
                    next_q.phase[r] = PH_RESET;
                    next_q.cause[r] = CAUSE_NONE;
                end
            endcase

            // Slave follows a hard master lockout unless enabled to continue
            if (!isMaster[r] && q.slvLockout && q.phase[r] != PH_LOCK) begin
                next_q.phase[r]      = PH_LOCK;
                next_q.cause[r]      = CAUSE_BY_MASTER;
                next_q.startEvent[r] = 1'b0;
            end

            next_q.seqOut[r]    = (next_q.phase[r] == PH_SEQ);
            next_q.lockOut[r]   = (next_q.phase[r] == PH_LOCK);
            next_q.singleOut[r] = (next_q.phase[r] == PH_SINGLE);
            next_q.threeOut[r]  = (next_q.phase[r] == PH_THREE);
            next_q.idleOut[r]   = (next_q.phase[r] == PH_RESET);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            q            <= '0;
            q.ctrl       <= CTRL_RESET;
            q.startTime  <= START_TIME_W'(START_TIME_RESET);
            q.phase      <= '{PH_RESET, PH_RESET};
            q.cause      <= '{CAUSE_NONE, CAUSE_NONE};
            q.idleOut    <= 2'h3;
        end else begin
            q <= next_q;
        end
    end

    assign s_axi_awready         = q.awReady;
    assign s_axi_wready          = q.wReady;
    assign s_axi_bresp           = q.bResp;
    assign s_axi_bvalid          = q.bValid;
    assign s_axi_arready         = q.arReady;
    assign s_axi_rdata           = q.rData;
    assign s_axi_rresp           = q.rResp;
    assign s_axi_rvalid          = q.rValid;
    assign recloseInitiate       = q.initiate;
    assign sequenceInProgress    = q.seqOut;
    assign sequenceStartEvent    = q.startEvent;
    assign anyInternalLockout    = q.lockOut;
    assign singlePhaseStartState = q.singleOut;
    assign threePhaseStartState  = q.threeOut;
    assign recloserIdle          = q.idleOut;
    assign slaveEnable           = q.slvEnable;
    assign slaveLockout          = q.slvLockout;

endmodule // rss_recloser_sequence_start

`default_nettype wire

// ### tb/recloser_sequence_start_bench.sv
`timescale 1ns/1ps
`default_nettype none
module recloser_sequence_start_bench;
    import rss_pkg::*;
    logic core_clk = 0, rst_b = 0, cleared = 0, initiateBlockInput = 0, s_axi_awvalid = 0;
    logic s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, tripActive;
    logic extTripActive = 0, extThreePhaseTripActive = 0, tripCountExceeded = 0, threePhaseTrip;
    logic singlePhaseModeInput = 0, threePhaseModeInput = 0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, recloseInitiate, slaveEnable, slaveLockout;
    logic [1:0] fault = 0, breakerCloseCommand = 0, sequenceReset = 0, attemptDone = 0;
    logic [1:0] lockoutOpenBreaker = 0, lockoutClosingFailure = 0, lockoutNoSynchronism = 0;
    logic [1:0] lockoutSwitchOntoFault = 0, s_axi_bresp, s_axi_rresp, resp, breakerAnyPoleOpen;
    logic [1:0] breakerAllPolesFlag, breakerThreePolesOpen, sequenceInProgress, sequenceStartEvent;
    logic [1:0] anyInternalLockout, singlePhaseStartState, threePhaseStartState, recloserIdle;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, protTrip;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    // Row: mode, three-phase fault, single start, three start, in sequence, lockout
    logic [6:0] rows [8] = '{7'h4A, 7'h51, 7'h36, 7'h20, 7'h6A, 7'h76, 7'h0A, 7'h16};
    int fails = 0, checked = 0, cyc = 0;
    rss_recloser_sequence_start #(.TICK_CYCLES_P(4)) uut (.*);
    rss_partner far (.*);
    assign breakerThreePolesOpen = breakerAllPolesFlag;
    initial forever #10 core_clk = ~core_clk;
    always @(posedge core_clk) if (++cyc == 6000) complete_run(1);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        fails += int'(s !== e);
        if (s !== e) $display("[FAIL] %s expected %h seen %h", n, e, s);
    endtask
    task automatic complete_run(input int extra);
        fails += extra;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
        do begin
            @(posedge core_clk);
            {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {s_axi_awvalid & ~s_axi_awready,
                s_axi_wvalid & ~s_axi_wready, s_axi_arvalid & ~s_axi_arready};
        end while (!(w ? s_axi_bvalid : s_axi_rvalid));
        {s_axi_bready, s_axi_rready} <= 2'h0;
        {resp, rd} = {w ? s_axi_bresp : s_axi_rresp, s_axi_rdata};
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        rst_b <= 1'h1;
        foreach (rows[i]) begin
            xfer(1'h1, ADDR_CTRL, {24'h00FF01, 6'h00, rows[i][6:5]});
            fault <= rows[i][4] ? 2'h2 : 2'h1;
            repeat (6) @(posedge core_clk);
            chk("start", {1'h1, rows[i][3:2]}, {recloseInitiate, singlePhaseStartState[0],
                threePhaseStartState[0]});
            cleared <= 1'h1;
            repeat (6) @(posedge core_clk);
            chk("outcome", rows[i][1:0], {sequenceInProgress[0], anyInternalLockout[0]});
            {fault, cleared, sequenceReset, breakerCloseCommand} <= 7'h0F;
            repeat (2) @(posedge core_clk);
            {sequenceReset, breakerCloseCommand} <= 4'h0;
            repeat (4) @(posedge core_clk);
        end
        xfer(1'h1, ADDR_START_TIME, 32'h2);
        xfer(1'h1, ADDR_CTRL, 32'h00FF0105);
        {fault, singlePhaseModeInput} <= 3'h3;
        repeat (20) @(posedge core_clk);
        xfer(1'h0, ADDR_STATUS, 32'h0);
        chk("failure", {2'h3, CAUSE_START_FAILURE}, {anyInternalLockout[0], rd[8], rd[6:3]});
        fault <= 2'h0;
        repeat (4) @(posedge core_clk);
        chk("held", 1'h1, anyInternalLockout[0]);
        breakerCloseCommand <= 2'h3;
        repeat (3) @(posedge core_clk);
        chk("idle", 1'h1, recloserIdle[0]);
        {breakerCloseCommand, initiateBlockInput, fault} <= 5'h05;
        repeat (8) @(posedge core_clk);
        chk("blocked", 2'h0, {singlePhaseStartState[0], threePhaseStartState[0]});
        xfer(1'h1, ADDR_CTRL, 32'h00FF010D);
        initiateBlockInput <= 1'h0;
        xfer(1'h0, 8'h0C, 32'h0);
        chk("unmapped", RESP_SLVERR, resp);
        chk("cmd", 1'h1, recloserIdle[0]);
        complete_run(0);
    end
endmodule // recloser_sequence_start_bench
`default_nettype wire

// ### tb/rss_partner.sv
`timescale 1ns/1ps
`default_nettype none
module rss_partner (
    input  wire logic       core_clk,
    input  wire logic [1:0] fault,
    input  wire logic       cleared,
    output logic [7:0]      protTrip,
    output logic            threePhaseTrip,
    output logic            tripActive,
    output logic [1:0]      breakerAnyPoleOpen,
    output logic [1:0]      breakerAllPolesFlag);
    // Fault 1 single-phase, 2 three-phase; clearing drops the trip and opens the poles
    always_ff @(posedge core_clk) begin
        {protTrip, threePhaseTrip, tripActive} <= {7'h00, |fault, fault[1], |fault} & {10{!cleared}};
        {breakerAnyPoleOpen, breakerAllPolesFlag} <= {{2{|fault}}, {2{fault[1]}}} & {4{cleared}};
    end
endmodule // rss_partner
`default_nettype wire

// ### tb/rss_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rss_sva (
    input wire logic       core_clk,
    input wire logic       rst_b,
    input wire logic [1:0] breakerCloseCommand,
    input wire logic [1:0] sequenceInProgress,
    input wire logic [1:0] sequenceStartEvent,
    input wire logic [1:0] anyInternalLockout,
    input wire logic [1:0] singlePhaseStartState,
    input wire logic [1:0] threePhaseStartState);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_start; singlePhaseStartState[0] || threePhaseStartState[0]; endsequence
    property p_pulse; sequenceStartEvent[0] |=> !sequenceStartEvent[0]; endproperty
    a_pulse: assert property (p_pulse) else $error("event too long");
    property p_evt; sequenceStartEvent[0] |-> $rose(sequenceInProgress[0]); endproperty
    a_evt: assert property (p_evt) else $error("event without sequence");
    property p_entry; s_start ##1 sequenceInProgress[0] |-> sequenceStartEvent[0]; endproperty
    a_entry: assert property (p_entry) else $error("start not flagged");
    property p_excl; anyInternalLockout[0] |-> !sequenceInProgress[0]; endproperty
    a_excl: assert property (p_excl) else $error("sequence in lockout");
    property p_hold; anyInternalLockout[0] && !breakerCloseCommand[0] |=> anyInternalLockout[0];
    endproperty
    a_hold: assert property (p_hold) else $error("lockout lost");
    property p_leave; $fell(anyInternalLockout[0]) |-> $past(breakerCloseCommand[0]); endproperty
    a_leave: assert property (p_leave) else $error("lockout left without close");
    property p_one; !(singlePhaseStartState[0] && threePhaseStartState[0]); endproperty
    a_one: assert property (p_one) else $error("two start states");
    property p_three; $rose(threePhaseStartState[0]) |-> !$past(sequenceInProgress[0]);
    endproperty
    a_three: assert property (p_three) else $error("bad three-phase entry");
endmodule // rss_sva
bind rss_recloser_sequence_start rss_sva u_sva (.*);
`default_nettype wire
